// File: hdl/aiap_pkg.sv
// Purpose: shared constants and types for the analog indirect access ports
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   offsets are byte addresses of aligned 32-bit words
package aiap_pkg;

    // ========================================================
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;

    // ========================================================
    // register offsets
    localparam logic [15:0] OFS_PORT_ONE   = 16'h5b38;
    localparam logic [15:0] OFS_PORT_TWO   = 16'h5b3c;
    localparam logic [15:0] OFS_PORT_THREE = 16'h5b40;
    localparam logic [15:0] OFS_PORT_ALL   = 16'h5b44;
    localparam logic [15:0] OFS_PORT_SHARE = 16'h5b48;
    localparam logic [15:0] OFS_IRQ_STATUS = 16'h5b60;
    localparam logic [15:0] OFS_IRQ_ENABLE = 16'h5b64;
    localparam logic [15:0] OFS_IRQ_CLEAR  = 16'h5b68;

    // ========================================================
    // port register field layout
    localparam int DONE_BIT = 31;
    localparam int CMD_BIT  = 30;
    localparam int ADDR_HI  = 15;
    localparam int ADDR_LO  = 8;
    localparam int DATA_HI  = 7;
    localparam int DATA_LO  = 0;

    // ========================================================
    // reset values
    localparam logic       DONE_RST = 1'b1;
    localparam logic       CMD_RST  = 1'b0;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ========================================================
    // port indices, also the target select code
    localparam int          N_PORTS    = 5;
    localparam int          SEL_W      = 3;
    localparam logic [2:0]  PORT_ONE   = 3'h0;
    localparam logic [2:0]  PORT_TWO   = 3'h1;
    localparam logic [2:0]  PORT_THREE = 3'h2;
    localparam logic [2:0]  PORT_ALL   = 3'h3;
    localparam logic [2:0]  PORT_SHARE = 3'h4;

    typedef logic [7:0] byte_t;

    // arbiter states, gray along idle -> busy -> idle
    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_BUSY = 2'b01
    } arb_state_e;

endpackage : aiap_pkg

// File: hdl/port_if.sv
// Purpose: request/answer bundle between one port and the arbiter
// Assumes: ack is a one-cycle pulse, rdata valid beside it
// Notes:   req stays high until ack
interface port_if;
    import aiap_pkg::*;
    logic  req;
    logic  we;
    byte_t addr;
    byte_t wdata;
    logic  ack;
    byte_t rdata;
    modport port (output req, we, addr, wdata, input ack, rdata);
    modport arb  (input req, we, addr, wdata, output ack, rdata);
endinterface : port_if

// File: hdl/irq_bank.sv
// Purpose: sticky event status, enable mask and one level interrupt
// Assumes: clear and enable writes are one-cycle strobes
// Notes:   an event in the clear cycle survives the clear
module irq_bank #(
    parameter int W = 5
) (
    // clock and reset
    input  wire logic         clock_in,
    input  wire logic         rst_n_in,
    // events and software writes
    input  wire logic [W-1:0] set_in,
    input  wire logic         en_wr_in,
    input  wire logic         clr_wr_in,
    input  wire logic [W-1:0] wdata_in,
    // state
    output logic      [W-1:0] status_out,
    output logic      [W-1:0] enable_out,
    output logic              irq_out
);
    logic [W-1:0] status_q;
    logic [W-1:0] enable_q;

    // ========================================================
    // sticky status: set beats clear so no event is lost
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            status_q <= '0;
        end else if (clr_wr_in) begin
            status_q <= (status_q & ~wdata_in) | set_in;
        end else begin
            status_q <= status_q | set_in;
        end
    end

    // enable mask
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            enable_q <= '0;
        end else if (en_wr_in) begin
            enable_q <= wdata_in;
        end
    end

    assign status_out = status_q;
    assign enable_out = enable_q;
    assign irq_out    = |(status_q & enable_q);
endmodule : irq_bank

// File: hdl/indirect_port.sv
// Purpose: one indirect port register with done flag and pending access
// Assumes: the arbiter acks each request exactly once
// Notes:   a write while done is low is ignored
module indirect_port #(
    parameter bit HAS_CMD = 1'b0
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // register write side
    input  wire logic        wr_in,
    input  wire logic [31:0] wdata_in,
    // register view and completion pulse
    output logic      [31:0] reg_out,
    output logic             done_out,
    // towards the arbiter
    port_if.port             tgt
);
    import aiap_pkg::*;

    logic  done_q;
    logic  cmd_q;
    byte_t addr_q;
    byte_t data_q;
    logic  accept;

    // only an idle port takes new data; software polls done first
    assign accept = wr_in && done_q;

    // ========================================================
    // done flag
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            done_q <= DONE_RST;
        end else if (accept) begin
            done_q <= 1'b0;
        end else if (tgt.ack) begin
            done_q <= 1'b1;
        end
    end

    // command, address: latched for the whole access
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cmd_q  <= CMD_RST;
            addr_q <= ADDR_RST;
        end else if (accept) begin
            cmd_q  <= HAS_CMD ? wdata_in[CMD_BIT] : 1'b1;
            addr_q <= wdata_in[ADDR_HI:ADDR_LO];
        end
    end

    // data byte: write data in, read data back
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            data_q <= DATA_RST;
        end else if (accept) begin
            data_q <= wdata_in[DATA_HI:DATA_LO];
        end else if (tgt.ack && !cmd_q) begin
            data_q <= tgt.rdata;
        end
    end

    assign tgt.req   = !done_q;
    assign tgt.we    = cmd_q;
    assign tgt.addr  = addr_q;
    assign tgt.wdata = data_q;
    assign done_out  = tgt.ack;
    assign reg_out   = {done_q, HAS_CMD ? cmd_q : 1'b0, 14'h0000,
                        addr_q, data_q};

    // ========================================================
    // checks
    property p_done_clear;
        @(posedge clock_in) disable iff (!rst_n_in)
        accept |=> !done_q;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done not cleared by accepted write");

    property p_done_cause;
        @(posedge clock_in) disable iff (!rst_n_in)
        $rose(done_q) |-> $past(tgt.ack);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done rose without target answer");

    property p_addr_take;
        @(posedge clock_in) disable iff (!rst_n_in)
        accept |=> addr_q == $past(wdata_in[ADDR_HI:ADDR_LO]);
    endproperty
    a_addr_take: assert property (p_addr_take)
        else $error("address byte not latched");

    property p_addr_hold;
        @(posedge clock_in) disable iff (!rst_n_in)
        !done_q && !tgt.ack |=> $stable(addr_q) && !done_q;
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address or done moved during access");

    property p_read_data;
        @(posedge clock_in) disable iff (!rst_n_in)
        tgt.ack && !cmd_q |=> done_q && data_q == $past(tgt.rdata);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data not present with done");

    property p_write_data;
        @(posedge clock_in) disable iff (!rst_n_in)
        accept |=> tgt.wdata == $past(wdata_in[DATA_HI:DATA_LO]);
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("write data byte not forwarded");

    property p_cmd_sel;
        @(posedge clock_in) disable iff (!rst_n_in)
        accept |=> tgt.we == (HAS_CMD ? $past(wdata_in[CMD_BIT]) : 1'b1);
    endproperty
    a_cmd_sel: assert property (p_cmd_sel)
        else $error("access type not as selected");
endmodule : indirect_port

// File: hdl/analog_indirect_access_port.sv
// Purpose: register bank of indirect ports into analog configuration space
// Assumes: one clock, synchronous active-low reset, single target bus
// Notes:   the shared offset holds either the clock module or general port
//
// Decided for this implementation: the address-and-strobe port.
module analog_indirect_access_port #(
    parameter bit SHARE_IS_GENERAL = 1'b1
) (
    // clock and reset
    input  wire logic                           clock_in,
    input  wire logic                           rst_n_in,
    // register port
    input  wire logic [aiap_pkg::ADDR_W-1:0]    addr_in,
    input  wire logic [aiap_pkg::DATA_W-1:0]    wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic      [aiap_pkg::DATA_W-1:0]    rdata_out,
    // analog target bus
    output logic                                tgt_req_out,
    output logic      [aiap_pkg::SEL_W-1:0]     tgt_sel_out,
    output logic                                tgt_we_out,
    output logic      [aiap_pkg::BYTE_W-1:0]    tgt_addr_out,
    output logic      [aiap_pkg::BYTE_W-1:0]    tgt_wdata_out,
    input  wire logic                           tgt_ack_in,
    input  wire logic [aiap_pkg::BYTE_W-1:0]    tgt_rdata_in,
    // interrupt
    output logic                                irq_out
);
    import aiap_pkg::*;

    // ========================================================
    // address decode
    logic [N_PORTS-1:0] port_wr;
    logic               irq_en_wr;
    logic               irq_clr_wr;
    logic [15:0]        port_ofs [N_PORTS];

    assign port_ofs[0] = OFS_PORT_ONE;
    assign port_ofs[1] = OFS_PORT_TWO;
    assign port_ofs[2] = OFS_PORT_THREE;
    assign port_ofs[3] = OFS_PORT_ALL;
    assign port_ofs[4] = OFS_PORT_SHARE;

    // write strobes per register
    always_comb begin
        for (int i = 0; i < N_PORTS; i++) begin
            port_wr[i] = wr_in && (addr_in == port_ofs[i]);
        end
    end
    assign irq_en_wr  = wr_in && (addr_in == OFS_IRQ_ENABLE);
    assign irq_clr_wr = wr_in && (addr_in == OFS_IRQ_CLEAR);

    // ========================================================
    // the ports
    port_if pif [N_PORTS] ();

    logic [31:0]        port_reg  [N_PORTS];
    logic [N_PORTS-1:0] port_done;
    logic [N_PORTS-1:0] req_v;
    logic [N_PORTS-1:0] we_v;
    byte_t              addr_v    [N_PORTS];
    byte_t              wdata_v   [N_PORTS];
    logic [N_PORTS-1:0] ack_v;

    generate
        for (genvar g = 0; g < N_PORTS; g++) begin : g_port
            // only the shared slot may carry the command bit
            indirect_port #(
                .HAS_CMD ((g == N_PORTS - 1) && SHARE_IS_GENERAL)
            ) u_port (
                .clock_in (clock_in),
                .rst_n_in (rst_n_in),
                .wr_in    (port_wr[g]),
                .wdata_in (wdata_in),
                .reg_out  (port_reg[g]),
                .done_out (port_done[g]),
                .tgt      (pif[g].port)
            );
            assign req_v[g]     = pif[g].req;
            assign we_v[g]      = pif[g].we;
            assign addr_v[g]    = pif[g].addr;
            assign wdata_v[g]   = pif[g].wdata;
            assign pif[g].ack   = ack_v[g];
            assign pif[g].rdata = tgt_rdata_in;
        end
    endgenerate

    // ========================================================
    // arbiter: one access on the target bus at a time
    arb_state_e           state_q;
    logic [SEL_W-1:0]     cur_q;
    logic [SEL_W-1:0]     pick;
    logic                 any_req;
    logic                 tgt_req_q;
    logic                 tgt_we_q;
    byte_t                tgt_addr_q;
    byte_t                tgt_wdata_q;

    // fixed priority, lowest index first; ports cannot starve since
    // each holds at most one access and software must repoll
    always_comb begin
        pick    = '0;
        any_req = 1'b0;
        for (int i = N_PORTS - 1; i >= 0; i--) begin
            if (req_v[i]) begin
                pick    = SEL_W'(i);
                any_req = 1'b1;
            end
        end
    end

    // state and current owner
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= ARB_IDLE;
            cur_q   <= '0;
        end else begin
            unique case (state_q)
                ARB_IDLE: begin
                    if (any_req) begin
                        state_q <= ARB_BUSY;
                        cur_q   <= pick;
                    end
                end
                ARB_BUSY: begin
                    if (tgt_ack_in) begin
                        state_q <= ARB_IDLE;
                    end
                end
                default: begin
                    state_q <= ARB_IDLE;
                end
            endcase
        end
    end

    // target bus request, held until the target answers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tgt_req_q <= 1'b0;
        end else if (state_q == ARB_IDLE && any_req) begin
            tgt_req_q <= 1'b1;
        end else if (state_q == ARB_BUSY && tgt_ack_in) begin
            tgt_req_q <= 1'b0;
        end
    end

    // target bus fields, loaded once per access
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tgt_we_q    <= 1'b0;
            tgt_addr_q  <= ADDR_RST;
            tgt_wdata_q <= DATA_RST;
        end else if (state_q == ARB_IDLE && any_req) begin
            tgt_we_q    <= we_v[pick];
            tgt_addr_q  <= addr_v[pick];
            tgt_wdata_q <= wdata_v[pick];
        end
    end

    // answer goes only to the owner of the access
    always_comb begin
        for (int i = 0; i < N_PORTS; i++) begin
            ack_v[i] = (state_q == ARB_BUSY) && tgt_ack_in
                       && (cur_q == SEL_W'(i));
        end
    end

    assign tgt_req_out   = tgt_req_q;
    assign tgt_sel_out   = cur_q;
    assign tgt_we_out    = tgt_we_q;
    assign tgt_addr_out  = tgt_addr_q;
    assign tgt_wdata_out = tgt_wdata_q;

    // ========================================================
    // interrupts: one status bit per port, set on completion
    logic [N_PORTS-1:0] irq_status;
    logic [N_PORTS-1:0] irq_enable;

    irq_bank #(
        .W (N_PORTS)
    ) u_irq (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .set_in     (port_done),
        .en_wr_in   (irq_en_wr),
        .clr_wr_in  (irq_clr_wr),
        .wdata_in   (wdata_in[N_PORTS-1:0]),
        .status_out (irq_status),
        .enable_out (irq_enable),
        .irq_out    (irq_out)
    );

    // ========================================================
    // read data, one cycle after the read strobe
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // clear register is write only; unmapped offsets read as zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        for (int i = 0; i < N_PORTS; i++) begin
            if (addr_in == port_ofs[i]) begin
                rdata_d = port_reg[i];
            end
        end
        if (addr_in == OFS_IRQ_STATUS) begin
            rdata_d = {{(32 - N_PORTS){1'b0}}, irq_status};
        end
        if (addr_in == OFS_IRQ_ENABLE) begin
            rdata_d = {{(32 - N_PORTS){1'b0}}, irq_enable};
        end
    end

    // data only stands in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_in) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata_out = rdata_q;

    // ========================================================
    // checks on the target bus
    property p_req_hold;
        @(posedge clock_in) disable iff (!rst_n_in)
        tgt_req_q && !tgt_ack_in |=>
            tgt_req_q && $stable(cur_q) && $stable(tgt_addr_q)
            && $stable(tgt_wdata_q) && $stable(tgt_we_q);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("target request changed before answer");

    property p_one_owner;
        @(posedge clock_in) disable iff (!rst_n_in)
        |ack_v |-> $onehot0(ack_v) && tgt_req_q;
    endproperty
    a_one_owner: assert property (p_one_owner)
        else $error("answer routed to more than one port");

    property p_gap;
        @(posedge clock_in) disable iff (!rst_n_in)
        tgt_req_q && tgt_ack_in |=> !tgt_req_q;
    endproperty
    a_gap: assert property (p_gap)
        else $error("request not dropped after answer");
endmodule : analog_indirect_access_port

// File: verification/analog_target_model.sv
// Purpose: behavioural analog configuration space behind the target bus
// Assumes: one request outstanding, fields stable until acknowledged
// Notes:   latency set by the bench; stale read byte is scrambled
module analog_target_model (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // target bus from the block, latency from the bench
    input  wire logic       tgt_req_in,
    input  wire logic [2:0] tgt_sel_in,
    input  wire logic       tgt_we_in,
    input  wire logic [7:0] tgt_addr_in,
    input  wire logic [7:0] tgt_wdata_in,
    input  wire logic [3:0] lat_in,
    // answer
    output logic            tgt_ack_out,
    output logic      [7:0] tgt_rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem [0:7][0:255];
    int         cnt;
    logic       served;

    // ========================================================
    // answer each request once, after lat_in idle cycles
    // the read byte flips every cycle out of reset except at a read ack so stale data shows
    always_ff @(posedge clock_in) begin
        tgt_ack_out   <= 1'b0;
        tgt_rdata_out <= ~tgt_rdata_out;
        if (!rst_n_in) begin
            cnt           <= 0;
            served        <= 1'b0;
            tgt_rdata_out <= 8'h00;
        end else if (tgt_req_in && !served) begin
            if (cnt >= int'(lat_in)) begin
                tgt_ack_out <= 1'b1;
                served      <= 1'b1;
                cnt         <= 0;
                if (tgt_we_in) begin
                    mem[tgt_sel_in][tgt_addr_in] <= tgt_wdata_in;
                end else begin
                    tgt_rdata_out <= mem[tgt_sel_in][tgt_addr_in];
                end
            end else begin
                cnt <= cnt + 1;
            end
        end else if (!tgt_req_in) begin
            served <= 1'b0;
        end
    end

endmodule : analog_target_model

// File: verification/tb_analog_indirect_access_port.sv
// Purpose: self-checking bench for the analog indirect access ports
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   random address, data and latency from a fixed seed
module tb_analog_indirect_access_port;
    timeunit 1ns;
    timeprecision 1ns;
    import aiap_pkg::*;

    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [31:0] rdata;
    logic        tgt_req, tgt_we, tgt_ack, irq;
    logic [2:0]  tgt_sel;
    logic [7:0]  tgt_addr, tgt_wdata, tgt_rdata;
    logic [3:0]  lat = 4'h0;
    logic [31:0] r;
    logic [7:0]  a8, d8, sa, sd;
    int          n_fail = 0;
    int          checked = 0;
    int          seed;
    logic [15:0] port_ofs [5] = '{OFS_PORT_ONE, OFS_PORT_TWO,
        OFS_PORT_THREE, OFS_PORT_ALL, OFS_PORT_SHARE};

    analog_indirect_access_port analog_indirect_access_port_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(bus_addr),
        .wdata_in(bus_wdata), .wr_in(bus_wr), .rd_in(bus_rd),
        .rdata_out(rdata), .tgt_req_out(tgt_req), .tgt_sel_out(tgt_sel),
        .tgt_we_out(tgt_we), .tgt_addr_out(tgt_addr),
        .tgt_wdata_out(tgt_wdata), .tgt_ack_in(tgt_ack),
        .tgt_rdata_in(tgt_rdata), .irq_out(irq));

    analog_target_model analog_target_model_inst (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .tgt_req_in(tgt_req),
        .tgt_sel_in(tgt_sel), .tgt_we_in(tgt_we), .tgt_addr_in(tgt_addr),
        .tgt_wdata_in(tgt_wdata), .lat_in(lat), .tgt_ack_out(tgt_ack),
        .tgt_rdata_out(tgt_rdata));

    // ========================================================
    // clock, 100 ns period
    initial begin
        forever #50 clock_in = ~clock_in;
    end

    // ========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock_in);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clock_in);
        bus_wr    <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
        @(posedge clock_in);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clock_in);
        bus_rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // software polls done before any new access
    task automatic poll(input logic [15:0] a, output logic [31:0] d);
        for (int i = 0; i < 40; i++) begin
            rd_reg(a, d);
            if (d[DONE_BIT] === 1'b1) return;
        end
        n_fail++;
        $display("FAIL %0t done never rose", $time);
    endtask : poll

    // bounded wait for a target request or acknowledge
    task automatic wait_tgt(input bit want_ack);
        for (int i = 0; i < 40; i++) begin
            if ((want_ack ? tgt_ack : tgt_req) === 1'b1) return;
            @(posedge clock_in);
            #1;
        end
        n_fail++;
        $display("FAIL %0t target bus stuck", $time);
    endtask : wait_tgt

    task automatic finish_test;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // ========================================================
    // watchdog, far beyond the expected few hundred cycles
    initial begin
        #2000000;
        n_fail++;
        finish_test();
    end

    // ========================================================
    // main sequence; the bench is the sole master, so no access collides
    initial begin
        seed = 59;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        for (int p = 0; p < 5; p++) begin
            rd_reg(port_ofs[p], r);
            chk(r, 32'h80000000, "reset view");
        end
        rd_reg(OFS_IRQ_STATUS, r);
        chk(r, 32'h0, "status reset");
        rd_reg(16'h5b70, r);
        chk(r, 32'h0, "unmapped read");
        wr_reg(OFS_IRQ_ENABLE, 32'h0000001f);
        // one random write through every port, slow target
        for (int p = 0; p < 5; p++) begin
            lat <= 4'(2 + ($unsigned($random(seed)) % 6));
            a8 = 8'($random(seed));
            d8 = 8'($random(seed));
            wr_reg(port_ofs[p], {2'b01, 14'h0, a8, d8});
            // the arbiter loads the target bus one edge after the accept
            @(posedge clock_in);
            #1 chk(32'(tgt_req), 32'h1, "request");
            chk(32'({tgt_sel, tgt_we, tgt_addr, tgt_wdata}),
                32'({3'(p), 1'b1, a8, d8}), "fields");
            rd_reg(port_ofs[p], r);
            chk(32'(r[DONE_BIT]), 32'h0, "busy");
            poll(port_ofs[p], r);
            chk(r, {1'b1, p == 4, 14'h0, a8, d8}, "done view");
            rd_reg(OFS_IRQ_STATUS, r);
            chk(r, 32'(1 << p), "status");
            chk(32'(irq), 32'h1, "irq high");
            wr_reg(OFS_IRQ_CLEAR, 32'(1 << p));
            #1 chk(32'(irq), 32'h0, "irq cleared");
            if (p == 4) begin
                sa = a8;
                sd = d8;
            end
        end
        // masked event still sets status, irq follows enable
        wr_reg(OFS_IRQ_ENABLE, 32'h0);
        wr_reg(OFS_PORT_ONE, 32'h40001234);
        poll(OFS_PORT_ONE, r);
        rd_reg(OFS_IRQ_STATUS, r);
        chk(r, 32'h1, "masked status");
        chk(32'(irq), 32'h0, "masked irq");
        wr_reg(OFS_IRQ_ENABLE, 32'h1);
        #1 chk(32'(irq), 32'h1, "unmasked irq");
        wr_reg(OFS_IRQ_CLEAR, 32'h1);
        // second write while busy is dropped
        lat <= 4'h7;
        wr_reg(OFS_PORT_TWO, 32'h40005a11);
        wr_reg(OFS_PORT_TWO, 32'h4000a522);
        poll(OFS_PORT_TWO, r);
        chk(r, 32'h80005a11, "busy write dropped");
        // read back through the general port
        lat <= 4'h5;
        wr_reg(OFS_PORT_SHARE, {2'b00, 14'h0, sa, 8'h00});
        @(posedge clock_in);
        #1 chk(32'({tgt_we, tgt_addr}), 32'({1'b0, sa}), "read req");
        poll(OFS_PORT_SHARE, r);
        chk(32'(r[7:0]), 32'(sd), "read data");
        // back to back on two ports, served one at a time
        lat <= 4'h4;
        wr_reg(OFS_PORT_ONE, 32'h40000101);
        wr_reg(OFS_PORT_THREE, 32'h40000303);
        wait_tgt(1'b1);
        @(posedge clock_in);
        #1 chk(32'(tgt_req), 32'h0, "gap after ack");
        wait_tgt(1'b0);
        chk(32'({tgt_sel, tgt_addr}), 32'({PORT_THREE, 8'h03}), "second");
        poll(OFS_PORT_THREE, r);
        chk(r, 32'h80000303, "second done");
        // mid-run reset returns the shared port to its idle view, irq and request low
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd_reg(OFS_PORT_SHARE, r);
        chk(r, 32'h80000000, "view after reset");
        chk(32'({irq, tgt_req}), 32'h0, "outputs after reset");
        finish_test();
    end

endmodule : tb_analog_indirect_access_port
